// ===== core/uirp_port.sv
// Indirect register port: address/data SFRs and core register map
`timescale 1ns/1ps
`default_nettype none
module uirp_port
  import uirp_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] in_flags_in,
  input wire logic [7:0] out_flags_in,
  input wire logic [7:0] cm_flags_in,
  input wire logic [7:0] frame_lo_in,
  input wire logic [7:0] frame_hi_in,
  input wire logic [7:0] fifo_rdata_in,
  input wire logic frame_mark_in,
  input wire logic early_in,
  output logic [7:0] sfr_rdata_out,
  output logic [7:0] fifo_wdata_out,
  output logic fifo_wr_out,
  output logic fifo_rd_out,
  output logic [1:0] fifo_ep_out,
  output logic [7:0] osc_trim_out
);
  typedef enum logic [1:0] {UIRP_IDLE, UIRP_FETCH} uirp_state_t;

  // True when the address names a listed core register
  function automatic logic uirp_mapped(input logic [5:0] a);
    case (a)
      UIRP_FUNC_ADDR, UIRP_POWER, UIRP_IN_FLAGS, UIRP_OUT_FLAGS, UIRP_CM_FLAGS,
      UIRP_IN_IE, UIRP_OUT_IE, UIRP_CM_IE, UIRP_FRAME_LO, UIRP_FRAME_HI,
      UIRP_INDEX, UIRP_CLOCK_RECOVERY_CONTROL, UIRP_EP0_CSR, UIRP_IN_CSRH, UIRP_OUT_CSRL,
      UIRP_OUT_CSRH, UIRP_EP0_CNT, UIRP_OUT_CNTH, UIRP_EP_ENABLE: uirp_mapped = 1'b1;
      default: uirp_mapped = (a >= UIRP_FIFO_BASE) && (a <= UIRP_FIFO_LAST);
    endcase
  endfunction : uirp_mapped

  // Port state
  uirp_state_t state, next_state;
  logic busy, next_busy;
  logic auto_rd, next_auto_rd;
  logic [5:0] core_register_select, next_core_register_select;
  logic [7:0] indirect_data_port, next_indirect_data_port;
  logic [1:0] fetch_cnt, next_fetch_cnt;
  logic [7:0] rdata, next_rdata;
  logic fifo_wr, next_fifo_wr;
  logic fifo_rd, next_fifo_rd;
  logic [7:0] fifo_wdata, next_fifo_wdata;
  logic [1:0] fifo_ep, next_fifo_ep;
  // Core registers
  logic [7:0] function_address, next_function_address;
  logic [7:0] power_management, next_power_management;
  logic [7:0] in_endpoint_irq_enables, next_in_endpoint_irq_enables;
  logic [7:0] out_endpoint_irq_enables, next_out_endpoint_irq_enables;
  logic [7:0] common_irq_enables, next_common_irq_enables;
  logic [3:0] endpoint_select_field, next_endpoint_select_field;
  logic [7:0] clock_recovery_control, next_clock_recovery_control;
  logic [7:0] endpoint_enable, next_endpoint_enable;
  logic [7:0] ep_ctl [UIRP_NUM_EP][4];
  logic [7:0] next_ep_ctl [UIRP_NUM_EP][4];
  logic [7:0] ep_cnt [UIRP_NUM_EP][2];
  logic [7:0] core_val;
  logic [1:0] ep;
  logic ep_ok;
  logic wr_addr, wr_data, rd_data, start_fetch;

  assign ep = endpoint_select_field[1:0];
  assign ep_ok = (endpoint_select_field <= UIRP_LAST_EP);
  assign wr_addr = sfr_wr_in && (sfr_addr_in == UIRP_SFR_ADDR);
  assign wr_data = sfr_wr_in && (sfr_addr_in == UIRP_SFR_DATA) && !busy;
  assign rd_data = sfr_rd_in && (sfr_addr_in == UIRP_SFR_DATA) && !busy;

  // Counts held at zero; byte counters belong to the FIFO engine
  always_comb begin
    for (int i = 0; i < UIRP_NUM_EP; i++) begin
      ep_cnt[i][0] = UIRP_ZERO;
      ep_cnt[i][1] = UIRP_ZERO;
    end
  end

  // Read multiplexer of the core map for the selected address
  always_comb begin
    core_val = UIRP_ZERO;
    case (core_register_select)
      UIRP_FUNC_ADDR: core_val = function_address;
      UIRP_POWER: core_val = power_management;
      UIRP_IN_FLAGS: core_val = in_flags_in;
      UIRP_OUT_FLAGS: core_val = out_flags_in;
      UIRP_CM_FLAGS: core_val = cm_flags_in;
      UIRP_IN_IE: core_val = in_endpoint_irq_enables;
      UIRP_OUT_IE: core_val = out_endpoint_irq_enables;
      UIRP_CM_IE: core_val = common_irq_enables;
      UIRP_FRAME_LO: core_val = frame_lo_in;
      UIRP_FRAME_HI: core_val = frame_hi_in;
      UIRP_INDEX: core_val = {4'h0, endpoint_select_field};
      UIRP_CLOCK_RECOVERY_CONTROL: core_val = clock_recovery_control;
      UIRP_EP_ENABLE: core_val = endpoint_enable;
      UIRP_EP0_CSR: core_val = ep_ok ? ep_ctl[ep][0] : UIRP_ZERO;
      UIRP_IN_CSRH: core_val = ep_ok ? ep_ctl[ep][1] : UIRP_ZERO;
      UIRP_OUT_CSRL: core_val = ep_ok ? ep_ctl[ep][2] : UIRP_ZERO;
      UIRP_OUT_CSRH: core_val = ep_ok ? ep_ctl[ep][3] : UIRP_ZERO;
      UIRP_EP0_CNT: core_val = ep_ok ? ep_cnt[ep][0] : UIRP_ZERO;
      UIRP_OUT_CNTH: core_val = ep_ok ? ep_cnt[ep][1] : UIRP_ZERO;
      default: core_val = uirp_mapped(core_register_select) ? fifo_rdata_in : UIRP_ZERO;
    endcase
  end

  // Address register, busy handshake and data port
  always_comb begin
    next_state = state;
    next_busy = busy;
    next_auto_rd = auto_rd;
    next_core_register_select = core_register_select;
    next_indirect_data_port = indirect_data_port;
    next_fetch_cnt = fetch_cnt;
    next_fifo_rd = 1'b0;
    start_fetch = 1'b0;
    if (wr_addr) begin
      next_core_register_select = sfr_wdata_in[5:0];
      next_auto_rd = sfr_wdata_in[UIRP_AUTO_BIT];
      start_fetch = sfr_wdata_in[UIRP_BUSY_BIT];
    end
    if (rd_data && auto_rd) begin
      start_fetch = 1'b1;
    end
    if (wr_data) begin
      next_indirect_data_port = sfr_wdata_in;
    end
    case (state)
      UIRP_IDLE: begin
        if (start_fetch) begin
          next_busy = 1'b1;
          next_fetch_cnt = UIRP_FETCH_CYCLES;
          next_state = UIRP_FETCH;
        end
      end
      UIRP_FETCH: begin
        if (fetch_cnt == 2'h1) begin
          next_indirect_data_port = core_val;
          next_fifo_rd = (core_register_select >= UIRP_FIFO_BASE) && uirp_mapped(core_register_select);
          next_busy = 1'b0;
          next_state = UIRP_IDLE;
        end
        next_fetch_cnt = fetch_cnt - 2'h1;
      end
      default: begin
        next_state = UIRP_IDLE;
        next_busy = 1'b0;
      end
    endcase
  end

  // Register writes through the data port
  always_comb begin
    next_function_address = function_address;
    next_power_management = power_management;
    next_in_endpoint_irq_enables = in_endpoint_irq_enables;
    next_out_endpoint_irq_enables = out_endpoint_irq_enables;
    next_common_irq_enables = common_irq_enables;
    next_endpoint_select_field = endpoint_select_field;
    next_clock_recovery_control = clock_recovery_control;
    next_endpoint_enable = endpoint_enable;
    next_ep_ctl = ep_ctl;
    next_fifo_wr = 1'b0;
    next_fifo_wdata = fifo_wdata;
    next_fifo_ep = fifo_ep;
    if (wr_data) begin
      case (core_register_select)
        UIRP_FUNC_ADDR: next_function_address = {1'b1, sfr_wdata_in[6:0]};
        UIRP_POWER: next_power_management = sfr_wdata_in;
        UIRP_IN_IE: next_in_endpoint_irq_enables = sfr_wdata_in;
        UIRP_OUT_IE: next_out_endpoint_irq_enables = sfr_wdata_in;
        UIRP_CM_IE: next_common_irq_enables = sfr_wdata_in;
        UIRP_INDEX: next_endpoint_select_field = sfr_wdata_in[3:0];
        UIRP_CLOCK_RECOVERY_CONTROL: next_clock_recovery_control = sfr_wdata_in;
        UIRP_EP_ENABLE: next_endpoint_enable = sfr_wdata_in;
        UIRP_EP0_CSR: if (ep_ok) next_ep_ctl[ep][0] = sfr_wdata_in;
        UIRP_IN_CSRH: if (ep_ok) next_ep_ctl[ep][1] = sfr_wdata_in;
        UIRP_OUT_CSRL: if (ep_ok) next_ep_ctl[ep][2] = sfr_wdata_in;
        UIRP_OUT_CSRH: if (ep_ok) next_ep_ctl[ep][3] = sfr_wdata_in;
        default: begin
          if (uirp_mapped(core_register_select) && (core_register_select >= UIRP_FIFO_BASE)) begin
            next_fifo_wr = 1'b1;
            next_fifo_wdata = sfr_wdata_in;
            next_fifo_ep = core_register_select[1:0];
          end
        end
      endcase
    end
    if (state == UIRP_FETCH && fetch_cnt == 2'h1) begin
      next_fifo_ep = core_register_select[1:0];
    end
  end

  // SFR read data
  always_comb begin
    next_rdata = UIRP_ZERO;
    if (sfr_addr_in == UIRP_SFR_ADDR) begin
      next_rdata = {next_busy, next_auto_rd, next_core_register_select};
    end else if (sfr_addr_in == UIRP_SFR_DATA) begin
      next_rdata = next_indirect_data_port;
    end
  end

  // State registers
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state <= UIRP_IDLE;
      busy <= 1'b0;
      auto_rd <= 1'b0;
      core_register_select <= 6'h00;
      indirect_data_port <= UIRP_ZERO;
      fetch_cnt <= 2'h0;
      rdata <= UIRP_ZERO;
      fifo_wr <= 1'b0;
      fifo_rd <= 1'b0;
      fifo_wdata <= UIRP_ZERO;
      fifo_ep <= 2'h0;
      function_address <= UIRP_ZERO;
      power_management <= UIRP_ZERO;
      in_endpoint_irq_enables <= UIRP_ZERO;
      out_endpoint_irq_enables <= UIRP_ZERO;
      common_irq_enables <= UIRP_ZERO;
      endpoint_select_field <= 4'h0;
      clock_recovery_control <= UIRP_CLOCK_RECOVERY_CONTROL_RST;
      endpoint_enable <= UIRP_ZERO;
      for (int i = 0; i < UIRP_NUM_EP; i++) begin
        for (int j = 0; j < 4; j++) begin
          ep_ctl[i][j] <= UIRP_ZERO;
        end
      end
    end else begin
      state <= next_state;
      busy <= next_busy;
      auto_rd <= next_auto_rd;
      core_register_select <= next_core_register_select;
      indirect_data_port <= next_indirect_data_port;
      fetch_cnt <= next_fetch_cnt;
      rdata <= next_rdata;
      fifo_wr <= next_fifo_wr;
      fifo_rd <= next_fifo_rd;
      fifo_wdata <= next_fifo_wdata;
      fifo_ep <= next_fifo_ep;
      function_address <= next_function_address;
      power_management <= next_power_management;
      in_endpoint_irq_enables <= next_in_endpoint_irq_enables;
      out_endpoint_irq_enables <= next_out_endpoint_irq_enables;
      common_irq_enables <= next_common_irq_enables;
      endpoint_select_field <= next_endpoint_select_field;
      clock_recovery_control <= next_clock_recovery_control;
      endpoint_enable <= next_endpoint_enable;
      ep_ctl <= next_ep_ctl;
    end
  end

  // Clock recovery engine steered by the recovery control register
  uirp_recovery u_recovery (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .enable_in(clock_recovery_control[UIRP_CR_ENABLE_BIT]),
    .low_speed_in(clock_recovery_control[UIRP_CR_LOW_BIT]),
    .single_step_in(clock_recovery_control[UIRP_CR_SINGLE_BIT]),
    .frame_mark_in(frame_mark_in),
    .early_in(early_in),
    .trim_out(osc_trim_out)
  );

  assign sfr_rdata_out = rdata;
  assign fifo_wr_out = fifo_wr;
  assign fifo_rd_out = fifo_rd;
  assign fifo_wdata_out = fifo_wdata;
  assign fifo_ep_out = fifo_ep;
endmodule : uirp_port
`default_nettype wire

// ===== include/uirp_pkg.sv
// Package: constants for the indirect core register port
package uirp_pkg;
  // Special-function addresses of the port
  localparam logic [7:0] UIRP_SFR_ADDR = 8'h96;
  localparam logic [7:0] UIRP_SFR_DATA = 8'h97;
  // Indirect address register fields
  localparam int UIRP_BUSY_BIT = 7;
  localparam int UIRP_AUTO_BIT = 6;
  // Core register map
  localparam logic [5:0] UIRP_FUNC_ADDR = 6'h00;
  localparam logic [5:0] UIRP_POWER = 6'h01;
  localparam logic [5:0] UIRP_IN_FLAGS = 6'h02;
  localparam logic [5:0] UIRP_OUT_FLAGS = 6'h04;
  localparam logic [5:0] UIRP_CM_FLAGS = 6'h06;
  localparam logic [5:0] UIRP_IN_IE = 6'h07;
  localparam logic [5:0] UIRP_OUT_IE = 6'h09;
  localparam logic [5:0] UIRP_CM_IE = 6'h0B;
  localparam logic [5:0] UIRP_FRAME_LO = 6'h0C;
  localparam logic [5:0] UIRP_FRAME_HI = 6'h0D;
  localparam logic [5:0] UIRP_INDEX = 6'h0E;
  localparam logic [5:0] UIRP_CLOCK_RECOVERY_CONTROL = 6'h0F;
  localparam logic [5:0] UIRP_EP0_CSR = 6'h11;
  localparam logic [5:0] UIRP_IN_CSRH = 6'h12;
  localparam logic [5:0] UIRP_OUT_CSRL = 6'h14;
  localparam logic [5:0] UIRP_OUT_CSRH = 6'h15;
  localparam logic [5:0] UIRP_EP0_CNT = 6'h16;
  localparam logic [5:0] UIRP_OUT_CNTH = 6'h17;
  localparam logic [5:0] UIRP_EP_ENABLE = 6'h1E;
  localparam logic [5:0] UIRP_FIFO_BASE = 6'h20;
  localparam logic [5:0] UIRP_FIFO_LAST = 6'h23;
  // Reset values
  localparam logic [7:0] UIRP_CLOCK_RECOVERY_CONTROL_RST = 8'h0F;
  localparam logic [7:0] UIRP_TRIM_RST = 8'h80;
  // Clock recovery control fields
  localparam int UIRP_CR_ENABLE_BIT = 7;
  localparam int UIRP_CR_SINGLE_BIT = 6;
  localparam int UIRP_CR_LOW_BIT = 5;
  localparam logic [7:0] UIRP_ZERO = 8'h00;
  // Fetch latency in cycles
  localparam logic [1:0] UIRP_FETCH_CYCLES = 2'h2;
  localparam int UIRP_NUM_EP = 4;
  localparam logic [3:0] UIRP_LAST_EP = 4'h3;
endpackage : uirp_pkg

// ===== core/uirp_recovery.sv
// Clock recovery oscillator trim engine driven from received bit timing
`timescale 1ns/1ps
`default_nettype none
module uirp_recovery
  import uirp_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic enable_in,
  input wire logic low_speed_in,
  input wire logic single_step_in,
  input wire logic frame_mark_in,
  input wire logic early_in,
  output logic [7:0] trim_out
);
  logic [7:0] trim;
  logic [7:0] next_trim;

  // Nudge the oscillator toward received timing on each frame marker
  always_comb begin
    next_trim = trim;
    if (enable_in && frame_mark_in) begin
      if (early_in) begin
        next_trim = (single_step_in || low_speed_in) ? trim - 8'h01 : trim - 8'h02;
      end else begin
        next_trim = (single_step_in || low_speed_in) ? trim + 8'h01 : trim + 8'h02;
      end
    end
  end

  // Trim register
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      trim <= UIRP_TRIM_RST;
    end else begin
      trim <= next_trim;
    end
  end

  assign trim_out = trim;
endmodule : uirp_recovery
`default_nettype wire

// ===== bench/uirp_cpu_model.sv
// Processor model driving the special-function register bus
`timescale 1ns/1ps
`default_nettype none
module uirp_cpu_model (
  input wire logic clock_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  // Bus idle at time zero
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // Write strobe held through one edge, then one idle edge
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clock_in);
    #1;
    wr_out = 1'b0;
    wdata_out = ~d; // Released data shows no stale byte
    @(posedge clock_in);
    #1;
  endtask : sfr_wr
  // Read strobe; registered answer taken at the sampling edge
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clock_in);
    #1;
    rd_out = 1'b0;
    d = rdata_in;
    @(posedge clock_in);
    #1;
  endtask : sfr_rd
endmodule : uirp_cpu_model
`default_nettype wire

// ===== bench/uirp_port_checker.sv
// Port-level assertions for the indirect register port
`timescale 1ns/1ps
`default_nettype none
module uirp_port_checker
  import uirp_pkg::*;
(
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic [7:0] fifo_wdata_out,
  input wire logic fifo_wr_out,
  input wire logic fifo_rd_out,
  input wire logic [7:0] osc_trim_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // Address register write that requests a fetch
  sequence fetch_go;
    sfr_wr_in && sfr_addr_in == UIRP_SFR_ADDR && sfr_wdata_in[UIRP_BUSY_BIT];
  endsequence
  chk_reset_vals: assert property ($fell(srst_in) |-> osc_trim_out == UIRP_TRIM_RST && !fifo_wr_out && !fifo_rd_out)
    else $error("outputs wrong after reset");
  chk_addr_echo: assert property (sfr_wr_in && sfr_addr_in == UIRP_SFR_ADDR |=> sfr_rdata_out[6:0] == $past(sfr_wdata_in[6:0]))
    else $error("address register readback wrong");
  chk_busy_up: assert property (fetch_go ##1 sfr_addr_in == UIRP_SFR_ADDR |=> sfr_rdata_out[UIRP_BUSY_BIT])
    else $error("busy not set during fetch");
  chk_busy_done: assert property (fetch_go ##1 (sfr_addr_in == UIRP_SFR_ADDR) [*3] |-> !sfr_rdata_out[UIRP_BUSY_BIT])
    else $error("busy not cleared after fetch");
  chk_fifo_wr_src: assert property (fifo_wr_out |-> $past(sfr_wr_in) && $past(sfr_addr_in) == UIRP_SFR_DATA)
    else $error("fifo load without data port write");
  chk_fifo_wdata: assert property (fifo_wr_out |-> fifo_wdata_out == $past(sfr_wdata_in))
    else $error("fifo load byte wrong");
  chk_unload_once: assert property (fifo_rd_out |=> !fifo_rd_out)
    else $error("fifo unload longer than one cycle");
  chk_read_no_load: assert property (sfr_rd_in && !sfr_wr_in |=> !fifo_wr_out)
    else $error("fifo load on a read");
  cov_fetch: cover property (fetch_go);
  cov_load: cover property (fifo_wr_out);
  cov_unload: cover property (fifo_rd_out);
endmodule : uirp_port_checker
bind uirp_port uirp_port_checker u_chk (.clock_in, .srst_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in,
  .sfr_rdata_out, .fifo_wdata_out, .fifo_wr_out, .fifo_rd_out, .osc_trim_out);
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the indirect register port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uirp_pkg::*;
  logic clock_in, srst_in, sfr_wr, sfr_rd, frame_mark, early, fifo_wr, fifo_rd;
  logic [7:0] sfr_addr, sfr_wdata, rdata, fifo_rdata, trim, fifo_wdata, wr_seen, v;
  logic [1:0] fifo_ep, ep_seen;
  int error_cnt = 0;
  int checked = 0;
  int unload_cnt = 0;
  logic [5:0] ra [5] = '{UIRP_IN_FLAGS, UIRP_OUT_FLAGS, UIRP_CM_FLAGS, UIRP_FRAME_LO, UIRP_FRAME_HI};
  logic [7:0] rv [5] = '{8'h3C, 8'hC3, 8'h5A, 8'h12, 8'h07};
  logic [5:0] wa [4] = '{UIRP_IN_IE, UIRP_OUT_IE, UIRP_CM_IE, UIRP_EP_ENABLE};
  uirp_cpu_model cpu (.clock_in(clock_in), .rdata_in(rdata), .addr_out(sfr_addr), .wdata_out(sfr_wdata),
    .wr_out(sfr_wr), .rd_out(sfr_rd));
  uirp_port uut (.clock_in(clock_in), .srst_in(srst_in), .sfr_addr_in(sfr_addr), .sfr_wdata_in(sfr_wdata),
    .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd), .in_flags_in(rv[0]), .out_flags_in(rv[1]), .cm_flags_in(rv[2]),
    .frame_lo_in(rv[3]), .frame_hi_in(rv[4]), .fifo_rdata_in(fifo_rdata), .frame_mark_in(frame_mark),
    .early_in(early), .sfr_rdata_out(rdata), .fifo_wdata_out(fifo_wdata), .fifo_wr_out(fifo_wr),
    .fifo_rd_out(fifo_rd), .fifo_ep_out(fifo_ep), .osc_trim_out(trim));
  // Clock, free running so core registers are always reachable
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // Capture of each fifo load and count of fifo unloads
  always @(posedge clock_in) begin
    if (fifo_wr === 1'b1) begin
      wr_seen <= fifo_wdata;
      ep_seen <= fifo_ep;
    end
    if (fifo_rd === 1'b1) begin
      unload_cnt <= unload_cnt + 1;
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // Bounded poll until the busy bit reads clear
  task automatic wait_idle;
    int i;
    v = 8'hFF;
    for (i = 0; i < 20 && v[7] !== 1'b0; i++) cpu.sfr_rd(UIRP_SFR_ADDR, v);
    if (v[7] !== 1'b0) begin
      error_cnt++;
      $display("CHECK FAILED busy expected 0 seen %h", v[7]);
      print_verdict();
    end
  endtask : wait_idle
  task automatic core_wr(input logic [5:0] a, input logic [7:0] d);
    wait_idle();
    cpu.sfr_wr(UIRP_SFR_ADDR, {2'b00, a});
    cpu.sfr_wr(UIRP_SFR_DATA, d);
  endtask : core_wr
  task automatic core_rd(input logic [5:0] a, input logic [7:0] e, input string n);
    wait_idle();
    cpu.sfr_wr(UIRP_SFR_ADDR, {2'b10, a});
    wait_idle();
    cpu.sfr_rd(UIRP_SFR_DATA, v);
    chk(n, e, v);
  endtask : core_rd
  // Frame markers, each sampled at one edge, three quiet edges apart
  task automatic pulse_marks(input int n);
    for (int k = 0; k < n; k++) begin
      frame_mark = 1'b1;
      @(posedge clock_in);
      #1;
      frame_mark = 1'b0;
      repeat (3) @(posedge clock_in);
      #1;
    end
  endtask : pulse_marks
  // Main sequence
  initial begin
    srst_in = 1'b1;
    fifo_rdata = 8'h61;
    frame_mark = 1'b0;
    early = 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    srst_in = 1'b0;
    chk("trim", UIRP_TRIM_RST, trim);
    cpu.sfr_rd(UIRP_SFR_DATA, v);
    chk("data", 8'h00, v);
    core_rd(UIRP_CLOCK_RECOVERY_CONTROL, UIRP_CLOCK_RECOVERY_CONTROL_RST, "clock_recovery_control");
    for (int k = 0; k < 5; k++) begin
      core_wr(ra[k], 8'hFF);
      core_rd(ra[k], rv[k], "ro");
    end
    for (int k = 0; k < 4; k++) begin
      core_wr(wa[k], 8'(8'hA0 + k));
      core_rd(wa[k], 8'(8'hA0 + k), "rw");
    end
    core_wr(6'h03, 8'h5A);
    core_rd(6'h03, 8'h00, "unmapped");
    core_rd(6'h3F, 8'h00, "unmapped");
    core_wr(UIRP_FUNC_ADDR, 8'h05);
    core_rd(UIRP_FUNC_ADDR, 8'h85, "function_address");
    core_wr(UIRP_INDEX, 8'hF2);
    core_rd(UIRP_INDEX, 8'h02, "index");
    // Same register written twice, then read twice, with no address reload between writes
    wait_idle();
    cpu.sfr_wr(UIRP_SFR_DATA, 8'h01);
    wait_idle();
    cpu.sfr_wr(UIRP_SFR_DATA, 8'h03);
    core_rd(UIRP_INDEX, 8'h03, "index twice");
    core_rd(UIRP_INDEX, 8'h03, "index reread");
    for (int k = 0; k < 4; k++) begin
      core_wr(UIRP_INDEX, 8'(k));
      core_wr(UIRP_OUT_CSRH, 8'(8'h01 + k));
    end
    for (int k = 0; k < 4; k++) begin
      core_wr(UIRP_INDEX, 8'(k));
      core_rd(UIRP_OUT_CSRH, 8'(8'h01 + k), "indexed");
    end
    core_wr(UIRP_INDEX, 8'h05);
    core_wr(UIRP_OUT_CSRH, 8'hEE);
    core_rd(UIRP_OUT_CSRH, 8'h00, "reserved");
    core_wr(UIRP_INDEX, 8'h01);
    core_rd(UIRP_OUT_CSRH, 8'h02, "no alias");
    core_wr(UIRP_FIFO_BASE + 6'h02, 8'h3C);
    chk("fifo byte", 8'h3C, wr_seen);
    chk("fifo ep", 8'h02, {6'h00, ep_seen});
    // Block read of endpoint 1 with auto-read, then a manual read that must not refetch
    wait_idle();
    cpu.sfr_wr(UIRP_SFR_ADDR, 8'hE1);
    wait_idle();
    fifo_rdata = 8'h62;
    cpu.sfr_rd(UIRP_SFR_DATA, v);
    chk("auto first", 8'h61, v);
    wait_idle();
    chk("auto addr", 8'h61, v);
    cpu.sfr_rd(UIRP_SFR_DATA, v);
    chk("auto next", 8'h62, v);
    wait_idle();
    chk("unloads", 8'h03, 8'(unload_cnt));
    chk("unload ep", 8'h01, {6'h00, fifo_ep});
    cpu.sfr_wr(UIRP_SFR_ADDR, 8'h21);
    fifo_rdata = 8'h63;
    cpu.sfr_rd(UIRP_SFR_DATA, v);
    chk("manual data", 8'h62, v);
    cpu.sfr_rd(UIRP_SFR_ADDR, v);
    chk("manual idle", 8'h21, v);
    chk("unloads", 8'h03, 8'(unload_cnt));
    // Recovery trim: step 2 at full speed, step 1 at low speed or single step
    core_wr(UIRP_CLOCK_RECOVERY_CONTROL, 8'h8F);
    core_rd(UIRP_CLOCK_RECOVERY_CONTROL, 8'h8F, "clock_recovery_control");
    pulse_marks(40);
    chk("trim full", 8'h30, trim);
    core_wr(UIRP_CLOCK_RECOVERY_CONTROL, 8'hAF);
    early = 1'b0;
    pulse_marks(8);
    chk("trim low", 8'h38, trim);
    core_wr(UIRP_CLOCK_RECOVERY_CONTROL, 8'hCF);
    early = 1'b1;
    pulse_marks(4);
    chk("trim step", 8'h34, trim);
    core_wr(UIRP_CLOCK_RECOVERY_CONTROL, 8'h0F);
    pulse_marks(2);
    chk("trim off", 8'h34, trim);
    // Reset in mid-run returns the port and the trim to their reset values
    srst_in = 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    srst_in = 1'b0;
    chk("trim reset", UIRP_TRIM_RST, trim);
    cpu.sfr_rd(UIRP_SFR_DATA, v);
    chk("data reset", 8'h00, v);
    core_rd(UIRP_CLOCK_RECOVERY_CONTROL, UIRP_CLOCK_RECOVERY_CONTROL_RST, "clock_recovery_control reset");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
